// ==== logic/srm_regs.svh ====
// srm_regs.svh: register offsets, field positions, reset values and latencies
// for the reference-sync, edge monitor, time-stamp and overrange block.
// assumes 15-bit register addresses and 8-bit register data.
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

`define SRM_AW             15
`define SRM_DW             8
`define SRM_ADDR_OVR_CFG   15'h010A
`define SRM_ADDR_OVR_POL   15'h010B
`define SRM_ADDR_OUT_FMT   15'h0110
`define SRM_ADDR_LSB_OVR   15'h0116
`define SRM_ADDR_STATUS    15'h0140
`define SRM_ADDR_PIN_CFG   15'h0146
`define SRM_ADDR_SYNC_MASK 15'h014A
`define SRM_ADDR_TS_CTL    15'h0162
`define SRM_ADDR_DEC       15'h0169

`define SRM_PIN_SYNC       8'h00
`define SRM_PIN_OVR        8'h02
`define SRM_PIN_RST        8'hFF
`define SRM_TS_ON          2'h3
`define SRM_MASK_RST       8'h07
`define SRM_ST_DET         6
`define SRM_ST_OR          5
`define SRM_MK_DIV         0
`define SRM_MK_NCO         1
`define SRM_MK_RAMP        2
`define SRM_MK_RAMP_EN     3

`define SRM_CAP_OFS_PS     60
`define SRM_WIN_LO_PS      60
`define SRM_WIN_HI_PS      140
`define SRM_CAP_TAP        3
`define SRM_NTAPS          6
`define SRM_DATA_LAT       43
`define SRM_TS_LAT         8
`define SRM_CMD_BITS       16
`define SRM_DATA_BITS      8

`endif

// ==== logic/srm_pkg.sv ====
// srm_pkg: types shared by the reference-sync block.
// assumes srm_regs.svh supplies the numeric constants.
package srm_pkg;

  typedef enum logic [1:0] {
    SP_CMD,
    SP_DATA,
    SP_DONE
  } srm_spi_phase_type;

  typedef struct packed {
    logic        ovr;
    logic [15:0] data;
  } srm_sample_type;

  typedef struct packed {
    logic       ovr_en;
    logic       ovr_pol;
    logic       ddr;
    logic       lsb_ovr;
    logic [7:0] pin_cfg;
    logic [7:0] mask;
    logic [1:0] ts;
    logic [3:0] dec;
  } srm_cfg_type;

endpackage : srm_pkg

// ==== logic/srm_delay_line.sv ====
// srm_delay_line: fixed-depth pipeline of plain flip-flops.
// assumes DEPTH of at least one; output lags input by DEPTH clocks.
`timescale 1ns/1ps
module srm_delay_line #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage [DEPTH];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign dout = stage[DEPTH-1];

endmodule : srm_delay_line

// ==== logic/srm_top.sv ====
// srm_top: reference-sync input, edge-window monitor, time-stamp marker and
// overrange routing, configured over the serial register port.
// assumes all inputs synchronous to clk; ref_taps come from the analog
// capture line sampling the reference at fixed sub-cycle offsets.
`timescale 1ns/1ps
`include "srm_regs.svh"
module srm_top
  import srm_pkg::*;
#(
  parameter int DATA_LAT = `SRM_DATA_LAT,
  parameter int TS_LAT   = `SRM_TS_LAT
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // serial register port
  input  wire logic        spi_clk,
  input  wire logic        spi_en_n,
  input  wire logic        spi_din,
  output logic             spi_dout,
  output logic             spi_dout_oe,
  // general-purpose pin and reference capture taps
  input  wire logic        sync_input_pin,
  output logic             sync_pin_out,
  output logic             sync_pin_oe,
  input  wire logic [5:0]  ref_taps,
  // sample path
  input  wire logic [15:0] adc_data,
  input  wire logic        adc_clip,
  output logic [15:1]      out_data_hi,
  output logic             lsb_output_lane,
  output logic             out_ddr,
  output logic             ddc_lsb_ovr,
  // sync resets to the downconverter path
  output logic             div_reset,
  output logic             nco_phase_reset
);

  srm_cfg_type            cfg;
  srm_spi_phase_type      phase;
  logic                   sck_q;
  logic                   sck_rise;
  logic                   sck_fall;
  logic [4:0]             bit_cnt;
  logic [15:0]            cmd_sh;
  logic [7:0]             wr_sh;
  logic [7:0]             rd_sh;
  logic                   wr_stb;
  logic [`SRM_AW-1:0]     wr_addr;
  logic [7:0]             wr_data;
  logic [4:0]             st_flags;
  logic                   st_or;
  logic                   st_det;
  logic [4:0]             win_xor;
  logic                   ref_lvl;
  logic                   ref_prev;
  logic                   ref_rise;
  logic                   sync_sel;
  logic                   ddc_mode;
  logic                   ts_on;
  logic [15:0]            ramp;
  srm_sample_type         smp_in;
  srm_sample_type         smp_dly;
  logic                   mark_dly;

  function automatic logic [7:0] reg_read(input logic [`SRM_AW-1:0] a,
                                          input srm_cfg_type c);
    case (a)
      `SRM_ADDR_OVR_CFG:   reg_read = {7'h00, c.ovr_en};
      `SRM_ADDR_OVR_POL:   reg_read = {7'h00, c.ovr_pol};
      `SRM_ADDR_OUT_FMT:   reg_read = {7'h00, c.ddr};
      `SRM_ADDR_LSB_OVR:   reg_read = {7'h00, c.lsb_ovr};
      `SRM_ADDR_STATUS:    reg_read = {1'b0, st_det, st_or, st_flags};
      `SRM_ADDR_PIN_CFG:   reg_read = c.pin_cfg;
      `SRM_ADDR_SYNC_MASK: reg_read = c.mask;
      `SRM_ADDR_TS_CTL:    reg_read = {c.ts, 6'h00};
      `SRM_ADDR_DEC:       reg_read = {4'h0, c.dec};
      default:             reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // serial port: frame is read flag, 15-bit address, 8 data bits, msb first
  assign sck_rise = spi_clk & ~sck_q;
  assign sck_fall = ~spi_clk & sck_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= spi_clk;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase   <= SP_CMD;
      bit_cnt <= 5'h00;
      cmd_sh  <= 16'h0000;
      wr_sh   <= 8'h00;
      rd_sh   <= 8'h00;
      wr_stb  <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (spi_en_n) begin
        phase   <= SP_CMD;
        bit_cnt <= 5'h00;
      end else if (sck_rise) begin
        case (phase)
          SP_CMD: begin
            cmd_sh  <= {cmd_sh[14:0], spi_din};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'(`SRM_CMD_BITS - 1)) begin
              phase   <= SP_DATA;
              bit_cnt <= 5'h00;
              rd_sh   <= reg_read({cmd_sh[13:0], spi_din}, cfg);
            end
          end
          SP_DATA: begin
            wr_sh   <= {wr_sh[6:0], spi_din};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'(`SRM_DATA_BITS - 1)) begin
              phase   <= SP_DONE;
              wr_stb  <= ~cmd_sh[15];
              wr_addr <= cmd_sh[14:0];
              wr_data <= {wr_sh[6:0], spi_din};
            end
          end
          SP_DONE: begin
            phase <= SP_DONE;
          end
          default: begin
            phase <= SP_CMD;
          end
        endcase
      end else if (sck_fall && phase == SP_DATA) begin
        rd_sh <= {rd_sh[6:0], 1'b0};
      end
    end
  end

  // read data leaves on falling edges so the master samples on rising ones
  always_ff @(posedge clk) begin
    if (!nrst) begin
      spi_dout    <= 1'b0;
      spi_dout_oe <= 1'b0;
    end else begin
      if (sck_fall && phase == SP_DATA) begin
        spi_dout <= rd_sh[7];
      end
      spi_dout_oe <= ~spi_en_n & cmd_sh[15] & (phase == SP_DATA);
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg.ovr_en  <= 1'b1;
      cfg.ovr_pol <= 1'b0;
      cfg.ddr     <= 1'b0;
      cfg.lsb_ovr <= 1'b0;
      cfg.pin_cfg <= `SRM_PIN_RST;
      cfg.mask    <= `SRM_MASK_RST;
      cfg.ts      <= 2'h0;
      cfg.dec     <= 4'h0;
    end else if (wr_stb) begin
      case (wr_addr)
        `SRM_ADDR_OVR_CFG:   cfg.ovr_en  <= wr_data[0];
        `SRM_ADDR_OVR_POL:   cfg.ovr_pol <= wr_data[0];
        `SRM_ADDR_OUT_FMT:   cfg.ddr     <= wr_data[0];
        `SRM_ADDR_LSB_OVR:   cfg.lsb_ovr <= wr_data[0];
        `SRM_ADDR_PIN_CFG:   cfg.pin_cfg <= wr_data;
        `SRM_ADDR_SYNC_MASK: cfg.mask    <= wr_data;
        `SRM_ADDR_TS_CTL:    cfg.ts      <= wr_data[7:6];
        `SRM_ADDR_DEC:       cfg.dec     <= wr_data[3:0];
        default:             cfg.dec     <= cfg.dec;
      endcase
    end
  end

  assign sync_sel = (cfg.pin_cfg == `SRM_PIN_SYNC);
  assign ddc_mode = (cfg.dec != 4'h0);
  assign ts_on    = (cfg.ts == `SRM_TS_ON) & ~ddc_mode;

  // reference capture: the tap at the edge plus the fixed offset is the level
  assign ref_lvl  = sync_sel & ref_taps[`SRM_CAP_TAP];
  assign ref_rise = ref_lvl & ~ref_prev;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_lvl;
    end
  end

  // adjacent taps that disagree mark the window the transition fell into
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_win
      assign win_xor[g] = ref_taps[g] ^ ref_taps[g+1];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_flags <= 5'h00;
      st_or    <= 1'b0;
    end else if (ref_rise) begin
      st_flags <= win_xor;
      st_or    <= |win_xor;
    end
  end

  // a new edge in the clearing cycle wins, so no detection is lost
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_det <= 1'b0;
    end else if (ref_rise) begin
      st_det <= 1'b1;
    end else if (wr_stb && wr_addr == `SRM_ADDR_STATUS && wr_data[`SRM_ST_DET]) begin
      st_det <= 1'b0;
    end
  end

  // sync pulses for the downconverter path; one pulse suffices per edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_reset       <= 1'b0;
      nco_phase_reset <= 1'b0;
    end else begin
      div_reset       <= ref_rise & ddc_mode & cfg.mask[`SRM_MK_DIV];
      nco_phase_reset <= ref_rise & ddc_mode & cfg.mask[`SRM_MK_NCO];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ramp <= 16'h0000;
    end else if (ref_rise && !ddc_mode && cfg.mask[`SRM_MK_RAMP]) begin
      ramp <= 16'h0000;
    end else begin
      ramp <= ramp + 16'h0001;
    end
  end

  // overrange rides with its sample, so both share the same latency
  assign smp_in.ovr  = adc_clip & cfg.ovr_en;
  assign smp_in.data = cfg.mask[`SRM_MK_RAMP_EN] ? ramp : adc_data;

  srm_delay_line #(
    .WIDTH ($bits(srm_sample_type)),
    .DEPTH (DATA_LAT - 1)
  ) u_data_dly (
    .clk  (clk),
    .nrst (nrst),
    .din  (smp_in),
    .dout (smp_dly)
  );

  // marker takes its own short pipe, hence it runs ahead of its sample
  srm_delay_line #(
    .WIDTH (1),
    .DEPTH (TS_LAT - 1)
  ) u_mark_dly (
    .clk  (clk),
    .nrst (nrst),
    .din  (ref_rise & ts_on),
    .dout (mark_dly)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_data_hi     <= 15'h0000;
      lsb_output_lane <= 1'b0;
      out_ddr         <= 1'b0;
    end else begin
      out_data_hi <= smp_dly.data[15:1];
      out_ddr     <= cfg.ddr;
      // lane value is format independent; the serializer repeats it per half
      if (ts_on) begin
        lsb_output_lane <= mark_dly;
      end else if (cfg.lsb_ovr) begin
        lsb_output_lane <= smp_dly.ovr;
      end else begin
        lsb_output_lane <= smp_dly.data[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_pin_out <= 1'b0;
      sync_pin_oe  <= 1'b0;
      ddc_lsb_ovr  <= 1'b0;
    end else begin
      sync_pin_out <= smp_dly.ovr ^ cfg.ovr_pol;
      sync_pin_oe  <= (cfg.pin_cfg == `SRM_PIN_OVR);
      ddc_lsb_ovr  <= cfg.lsb_ovr & ddc_mode & smp_dly.ovr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_det_sticky;
    st_det && !(wr_stb && wr_addr == `SRM_ADDR_STATUS) |=> st_det;
  endproperty
  a_det_sticky: assert property (p_det_sticky)
    else $error("edge-seen bit dropped without a clear");

  property p_win_update;
    ref_rise |=> st_flags == $past(win_xor) && st_or == (|$past(win_xor));
  endproperty
  a_win_update: assert property (p_win_update)
    else $error("window flags not refreshed on reference edge");

  property p_or_summary;
    st_or == (|st_flags);
  endproperty
  a_or_summary: assert property (p_or_summary)
    else $error("summary bit disagrees with window flags");

  property p_nco_sync;
    ref_rise && ddc_mode && cfg.mask[`SRM_MK_NCO] |=> nco_phase_reset;
  endproperty
  a_nco_sync: assert property (p_nco_sync)
    else $error("oscillator phase not reset on reference edge");

  property p_ramp_reset;
    ref_rise && !ddc_mode && cfg.mask[`SRM_MK_RAMP] |=> ramp == 16'h0000;
  endproperty
  a_ramp_reset: assert property (p_ramp_reset)
    else $error("ramp not restarted on reference edge");

  property p_pin_gate;
    !sync_sel |-> !ref_rise;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("reference edge taken while pin not configured");

  property p_mark_lat;
    ref_rise && ts_on ##1 ts_on [*7] |=> lsb_output_lane;
  endproperty
  a_mark_lat: assert property (p_mark_lat)
    else $error("marker not on lsb lane eight cycles after edge");

  property p_data_lat;
    !cfg.mask[`SRM_MK_RAMP_EN] ##0 $stable(cfg.mask) [*1] ##42 1'b1
      |=> out_data_hi == $past(adc_data[15:1], 43);
  endproperty
  a_data_lat: assert property (p_data_lat)
    else $error("sample data latency is not 43 cycles");

  property p_ovr_pin;
    sync_pin_oe |-> sync_pin_out == ($past(smp_dly.ovr) ^ $past(cfg.ovr_pol));
  endproperty
  a_ovr_pin: assert property (p_ovr_pin)
    else $error("overrange pin does not follow delayed overrange");

endmodule : srm_top

// ==== bench/srm_ref_source.sv ====
// srm_ref_source: reference pulse source that feeds the analog capture taps.
// assumes the bench calls pulse() from its main sequence, one call at a time.
`timescale 1ns/1ps
module srm_ref_source (
  // clock
  input  wire logic       clk,
  // capture taps and pin level
  output logic      [5:0] ref_taps,
  output logic            pin_level
);
  assign pin_level = ref_taps[3];

  initial ref_taps = 6'h00;

  // k places the rising edge between tap k-1 and tap k; k of 0 is the
  // preferred placement half a cycle early, so every tap already sees it
  task automatic pulse(input int k);
    @(negedge clk);
    ref_taps = 6'h3F << k;
    @(negedge clk);
    ref_taps = 6'h3F;
    repeat (6) @(negedge clk);
    // single pulse only, a periodic reference would hide missed edges
    ref_taps = 6'h00;
    repeat (3) @(negedge clk);
  endtask : pulse
endmodule : srm_ref_source

// ==== bench/test_sync_ref_monitor_timestamp_ovr.sv ====
// test_sync_ref_monitor_timestamp_ovr: self-checking bench for srm_top.
// assumes srm_ref_source drives the capture taps; registers over the serial port.
`timescale 1ns/1ps
`include "srm_regs.svh"
module test_sync_ref_monitor_timestamp_ovr
  import srm_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        spi_clk;
  logic        spi_en_n;
  logic        spi_din;
  logic        spi_dout;
  logic        spi_dout_oe;
  logic        sync_pin_out;
  logic        sync_pin_oe;
  logic [5:0]  ref_taps;
  logic        pin_level;
  logic [15:0] adc_data;
  logic        adc_clip;
  logic [15:1] out_data_hi;
  logic        lsb_output_lane;
  logic        out_ddr;
  logic        ddc_lsb_ovr;
  logic        div_reset;
  logic        nco_phase_reset;
  logic [7:0]  rv;
  logic        oe_seen;
  int          errors;
  int          n_tests;
  int          n_div;
  int          n_nco;
  int          n;
  int          ks[4] = '{2, 1, 3, 0};
  logic [7:0]  ex[4] = '{8'h62, 8'h61, 8'h64, 8'h40};

  srm_top u_dut (
    .clk             (clk),
    .nrst            (nrst),
    .spi_clk         (spi_clk),
    .spi_en_n        (spi_en_n),
    .spi_din         (spi_din),
    .spi_dout        (spi_dout),
    .spi_dout_oe     (spi_dout_oe),
    .sync_input_pin  (pin_level),
    .sync_pin_out    (sync_pin_out),
    .sync_pin_oe     (sync_pin_oe),
    .ref_taps        (ref_taps),
    .adc_data        (adc_data),
    .adc_clip        (adc_clip),
    .out_data_hi     (out_data_hi),
    .lsb_output_lane (lsb_output_lane),
    .out_ddr         (out_ddr),
    .ddc_lsb_ovr     (ddc_lsb_ovr),
    .div_reset       (div_reset),
    .nco_phase_reset (nco_phase_reset)
  );

  srm_ref_source u_src (
    .clk       (clk),
    .ref_taps  (ref_taps),
    .pin_level (pin_level)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk) begin
    if (div_reset === 1'b1) n_div++;
    if (nco_phase_reset === 1'b1) n_nco++;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // spi_clk phases last 3 clk so the design's edge detector always sees them
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    @(negedge clk);
    spi_en_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      spi_clk = 1'b0;
      repeat (3) @(negedge clk);
      if (i >= 16) q[23-i] = spi_dout;
      if (i == 16) oe_seen = spi_dout_oe;
      spi_din = f[23-i];
      spi_clk = 1'b1;
      repeat (3) @(negedge clk);
    end
    spi_clk = 1'b0;
    repeat (3) @(negedge clk);
    spi_en_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : xfer

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d, rv);
  endtask : wr

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp, input string what);
    xfer(1'b1, a, 8'h00, rv);
    chk(what, exp, rv);
    chk({what, "_dout_enable"}, 8'h01, {7'h00, oe_seen});
  endtask : rd_chk

  task automatic wait_lane;
    n = 0;
    while (lsb_output_lane !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lane

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    spi_clk = 1'b0;
    spi_en_n = 1'b1;
    spi_din = 1'b0;
    adc_data = 16'h0000;
    adc_clip = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(`SRM_ADDR_PIN_CFG, 8'hFF, "pin_cfg");
    rd_chk(`SRM_ADDR_SYNC_MASK, 8'h07, "sync_mask");
    rd_chk(`SRM_ADDR_OVR_CFG, 8'h01, "overrange_cfg");
    rd_chk(`SRM_ADDR_STATUS, 8'h00, "ref_edge_window_status");
    rd_chk(15'h0001, 8'h00, "unmapped");
    $display("test reset values done");
    // pin still in its reset role: edges must not reach the monitor
    u_src.pulse(2);
    rd_chk(`SRM_ADDR_STATUS, 8'h00, "status_pin_unrouted");
    wr(`SRM_ADDR_PIN_CFG, `SRM_PIN_SYNC);
    for (int i = 0; i < 4; i++) begin
      u_src.pulse(ks[i]);
      rd_chk(`SRM_ADDR_STATUS, ex[i], "window_status");
    end
    wr(`SRM_ADDR_STATUS, 8'h40);
    rd_chk(`SRM_ADDR_STATUS, 8'h00, "edge_seen_cleared");
    $display("test edge monitor done");
    wr(`SRM_ADDR_DEC, 8'h01);
    u_src.pulse(0);
    chk("div_reset_count", 8'h01, 8'(n_div));
    chk("nco_reset_count", 8'h01, 8'(n_nco));
    wr(`SRM_ADDR_SYNC_MASK, 8'h02);
    u_src.pulse(0);
    chk("div_reset_masked", 8'h01, 8'(n_div));
    chk("nco_reset_only", 8'h02, 8'(n_nco));
    wr(`SRM_ADDR_DEC, 8'h00);
    u_src.pulse(0);
    chk("nco_reset_bypass", 8'h02, 8'(n_nco));
    $display("test sync resets done");
    @(negedge clk);
    adc_data = 16'hA5A4;
    @(negedge clk);
    adc_data = 16'h0000;
    // count from the cycle in which the sample was presented
    n = 1;
    while (out_data_hi !== 15'h52D2 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("data_latency", 8'd43, 8'(n));
    wr(`SRM_ADDR_OUT_FMT, 8'h01);
    chk("ddr_format", 8'h01, {7'h00, out_ddr});
    wr(`SRM_ADDR_TS_CTL, 8'hC0);
    fork
      u_src.pulse(0);
      begin
        // start counting on the negedge at which the taps rise
        @(negedge clk);
        wait_lane();
        chk("marker_latency", 8'd8, 8'(n));
        @(negedge clk);
        chk("marker_one_cycle", 8'h00, {7'h00, lsb_output_lane});
      end
    join
    wr(`SRM_ADDR_TS_CTL, 8'h00);
    $display("test time stamp done");
    // ramp replaces the samples and restarts on the edge
    wr(`SRM_ADDR_SYNC_MASK, 8'h0C);
    fork
      u_src.pulse(0);
      begin
        @(negedge clk);
        repeat (44) @(negedge clk);
        chk("ramp_restart_lo", 8'h00, {out_data_hi[7:1], lsb_output_lane});
        chk("ramp_restart_hi", 8'h00, out_data_hi[15:8]);
      end
    join
    $display("test ramp restart done");
    wr(`SRM_ADDR_LSB_OVR, 8'h01);
    wr(`SRM_ADDR_PIN_CFG, `SRM_PIN_OVR);
    chk("pin_drives_overrange", 8'h01, {7'h00, sync_pin_oe});
    @(negedge clk);
    adc_clip = 1'b1;
    @(negedge clk);
    adc_clip = 1'b0;
    wait_lane();
    chk("overrange_in_time", 8'h01, 8'(n <= 43));
    chk("overrange_pin", 8'h01, {7'h00, sync_pin_out});
    wr(`SRM_ADDR_DEC, 8'h01);
    @(negedge clk);
    adc_clip = 1'b1;
    @(negedge clk);
    adc_clip = 1'b0;
    n = 1;
    while (ddc_lsb_ovr !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("ddc_overrange_latency", 8'd43, 8'(n));
    $display("test overrange done");
    end_sim();
  end
endmodule : test_sync_ref_monitor_timestamp_ovr
